//--- common/crf_pkg.sv
// Constants and carrier types for the receive flag register block
`default_nettype none
package crf_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int TEC_W = 9;
   localparam int REC_W = 8;
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 4'h1;
   // Field positions in the flag register
   localparam int BIT_WAKE = 7;
   localparam int BIT_STAT = 6;
   localparam int RX_HI = 5;
   localparam int RX_LO = 4;
   localparam int TX_HI = 3;
   localparam int TX_LO = 2;
   // Reset values
   localparam logic RST_FLAG = 1'b0;
   localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
   // Error counter thresholds
   localparam logic [TEC_W-1:0] LIM_WARN = 9'h060;
   localparam logic [TEC_W-1:0] LIM_PASSIVE = 9'h080;
   localparam logic [TEC_W-1:0] LIM_OFF = 9'h100;
   // Bus status codes
   typedef enum logic [1:0] {
      CRF_OK = 2'h0,
      CRF_WARN = 2'h1,
      CRF_PASSIVE = 2'h2,
      CRF_OFF = 2'h3
   } crf_state_t;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } crf_bus_req_t;
   typedef struct packed {
      logic [TEC_W-1:0] tec;
      logic [REC_W-1:0] rec;
   } crf_err_cnt_t;
endpackage
`default_nettype wire

//--- hw/crf_receive_flags.sv
// Receive flag and bus status register of the CAN controller
//
// Summary of operation
// RL1: While init request and acknowledge are both high the flags are held at reset, and writes resume once both are low.
// RL2: The receiver and transmitter status fields are not touched by initialization mode.
// RL3: Bus activity seen in sleep mode with wake enable set raises the wake flag in bit 7.
// RL4: A wake interrupt is requested while the wake flag is set and its enable is high.
// RL5: A change of the bus status derived from the error counters raises the status change flag in bit 6.
// RL6: An error interrupt is requested while the status change flag is set and its enable is high.
// RL7: The status fields update only while no status change is pending and stay frozen otherwise.
// RL8: The receiver status sits in bits 5 to 4 and reads 00 while the receive counter is below 96.
// RL9: The transmitter status sits in bits 3 to 2 and reads 00 while the transmit counter is below 96.
// RL10: Writing one to a flag clears it, writing zero does nothing, and the status fields are read-only.
// RL11: Codes 01, 10 and 11 mean warning from 96, error passive from 128 and bus-off above 255.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`default_nettype none
module crf_receive_flags (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // Register port
   input wire crf_pkg::crf_bus_req_t i_bus,
   output logic [crf_pkg::DATA_W-1:0] o_rdata,
   // Controller state
   input wire logic i_init_request,
   input wire logic i_init_acknowledge,
   input wire logic i_sleep_mode,
   input wire logic i_wake_enable,
   input wire crf_pkg::crf_err_cnt_t i_err_cnt,
   // Receive pin activity, asynchronous
   input wire logic i_bus_activity,
   // Interrupts
   output logic o_wake_irq,
   output logic o_status_irq,
   output logic o_irq
);
   ////////////////////////////////////////////////////////////////////////
   // Bus status decode
   function automatic crf_pkg::crf_state_t state_of(
      input logic [crf_pkg::TEC_W-1:0] cnt,
      input logic has_off
   );
      crf_pkg::crf_state_t s;
      if (has_off && cnt >= crf_pkg::LIM_OFF) begin // [RL11]
         s = crf_pkg::CRF_OFF;
      end else if (cnt >= crf_pkg::LIM_PASSIVE) begin // [RL11]
         s = crf_pkg::CRF_PASSIVE;
      end else if (cnt >= crf_pkg::LIM_WARN) begin // [RL11]
         s = crf_pkg::CRF_WARN;
      end else begin
         s = crf_pkg::CRF_OK; // [RL8] [RL9]
      end
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State
   logic act_s1_q;
   logic act_s2_q;
   logic wake_flag_q;
   logic wake_flag_d;
   logic status_change_flag_q;
   logic status_change_flag_d;
   logic [1:0] rx_bus_state_q;
   logic [1:0] rx_bus_state_d;
   logic [1:0] tx_bus_state_q;
   logic [1:0] tx_bus_state_d;
   logic [1:0] rx_prev_q;
   logic [1:0] tx_prev_q;
   logic wake_ie_q;
   logic status_ie_q;
   logic [crf_pkg::DATA_W-1:0] rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Decode
   wire init_hold = i_init_request && i_init_acknowledge;
   wire init_free = !i_init_request && !i_init_acknowledge;
   wire wr_flags = i_bus.wr && (i_bus.addr == crf_pkg::OFS_FLAGS) && init_free;
   wire wr_ie = i_bus.wr && (i_bus.addr == crf_pkg::OFS_IRQ_EN);
   wire clr_wake = wr_flags && i_bus.wdata[crf_pkg::BIT_WAKE];
   wire clr_stat = wr_flags && i_bus.wdata[crf_pkg::BIT_STAT];
   wire [1:0] rx_cur = state_of({1'b0, i_err_cnt.rec}, 1'b0);
   wire [1:0] tx_cur = state_of(i_err_cnt.tec, 1'b1);
   wire wake_evt = act_s2_q && i_sleep_mode && i_wake_enable; // [RL3]
   wire stat_evt = (rx_cur != rx_prev_q) || (tx_cur != tx_prev_q); // [RL5]
   wire [crf_pkg::DATA_W-1:0] flags_view = {
      wake_flag_q, status_change_flag_q, rx_bus_state_q, tx_bus_state_q, 2'h0};
   wire [crf_pkg::DATA_W-1:0] ie_view = {wake_ie_q, status_ie_q, 6'h00};
   wire [crf_pkg::DATA_W-1:0] rd_mux =
      (i_bus.addr == crf_pkg::OFS_FLAGS) ? flags_view :
      (i_bus.addr == crf_pkg::OFS_IRQ_EN) ? ie_view : crf_pkg::RST_DATA;

   ////////////////////////////////////////////////////////////////////////
   // Next state: set beats a same-cycle clear
   always_comb begin
      wake_flag_d = wake_flag_q;
      status_change_flag_d = status_change_flag_q;
      if (clr_wake) begin
         wake_flag_d = crf_pkg::RST_FLAG; // [RL10]
      end
      if (clr_stat) begin
         status_change_flag_d = crf_pkg::RST_FLAG; // [RL10]
      end
      if (wake_evt) begin
         wake_flag_d = 1'b1; // [RL3]
      end
      if (stat_evt) begin
         status_change_flag_d = 1'b1; // [RL5]
      end
      if (init_hold) begin
         wake_flag_d = crf_pkg::RST_FLAG; // [RL1]
         status_change_flag_d = crf_pkg::RST_FLAG; // [RL1]
      end
   end

   // Fields freeze while a change is pending; init mode does not touch them
   assign rx_bus_state_d = status_change_flag_q ? rx_bus_state_q : rx_cur; // [RL7] [RL2]
   assign tx_bus_state_d = status_change_flag_q ? tx_bus_state_q : tx_cur; // [RL7] [RL2]

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge i_clk_sys) begin
      act_s1_q <= i_bus_activity;
      act_s2_q <= act_s1_q;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         wake_flag_q <= crf_pkg::RST_FLAG;
         status_change_flag_q <= crf_pkg::RST_FLAG;
         rx_bus_state_q <= crf_pkg::CRF_OK;
         tx_bus_state_q <= crf_pkg::CRF_OK;
         rx_prev_q <= crf_pkg::CRF_OK;
         tx_prev_q <= crf_pkg::CRF_OK;
      end else begin
         wake_flag_q <= wake_flag_d;
         status_change_flag_q <= status_change_flag_d;
         rx_bus_state_q <= rx_bus_state_d;
         tx_bus_state_q <= tx_bus_state_d;
         rx_prev_q <= rx_cur;
         tx_prev_q <= tx_cur;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         wake_ie_q <= crf_pkg::RST_FLAG;
         status_ie_q <= crf_pkg::RST_FLAG;
      end else if (wr_ie) begin
         wake_ie_q <= i_bus.wdata[crf_pkg::BIT_WAKE];
         status_ie_q <= i_bus.wdata[crf_pkg::BIT_STAT];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         rdata_q <= crf_pkg::RST_DATA;
      end else if (i_bus.rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= crf_pkg::RST_DATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_rdata = rdata_q;
   assign o_wake_irq = wake_flag_q && wake_ie_q; // [RL4]
   assign o_status_irq = status_change_flag_q && status_ie_q; // [RL6]
   assign o_irq = o_wake_irq || o_status_irq;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   wire [crf_pkg::TEC_W-1:0] rec_wide = {1'b0, i_err_cnt.rec};
   a_init_holds_flags: assert property ( // [RL1]
      @(posedge i_clk_sys) disable iff (i_reset)
      init_hold |=> !wake_flag_q && !status_change_flag_q)
      else $error("flags not held during init");

   a_fields_keep_init: assert property ( // [RL2]
      @(posedge i_clk_sys) disable iff (i_reset)
      init_hold && !status_change_flag_q
      |=> rx_bus_state_q == $past(rx_cur) && tx_bus_state_q == $past(tx_cur))
      else $error("status fields disturbed by init");

   a_wake_sets: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_reset)
      act_s2_q && i_sleep_mode && i_wake_enable && !init_hold |=> wake_flag_q)
      else $error("wake flag not set");

   a_wake_irq_level: assert property ( // [RL4]
      @(posedge i_clk_sys) disable iff (i_reset)
      o_wake_irq == (flags_view[crf_pkg::BIT_WAKE] && ie_view[crf_pkg::BIT_WAKE]))
      else $error("wake interrupt level wrong");

   a_status_sets: assert property ( // [RL5]
      @(posedge i_clk_sys) disable iff (i_reset)
      ($changed(tx_cur) || $changed(rx_cur)) && !init_hold |=> status_change_flag_q)
      else $error("status change flag not set");

   a_status_irq_level: assert property ( // [RL6]
      @(posedge i_clk_sys) disable iff (i_reset)
      status_change_flag_q && status_ie_q |-> o_status_irq && o_irq)
      else $error("error interrupt missing");

   a_fields_frozen: assert property ( // [RL7]
      @(posedge i_clk_sys) disable iff (i_reset)
      status_change_flag_q |=> $stable(rx_bus_state_q) && $stable(tx_bus_state_q))
      else $error("status fields moved while pending");

   a_rx_ok_code: assert property ( // [RL8]
      @(posedge i_clk_sys) disable iff (i_reset)
      !status_change_flag_q && rec_wide < crf_pkg::LIM_WARN
      |=> rx_bus_state_q == crf_pkg::CRF_OK)
      else $error("receiver status not ok");

   a_tx_ok_code: assert property ( // [RL9]
      @(posedge i_clk_sys) disable iff (i_reset)
      !status_change_flag_q && i_err_cnt.tec < crf_pkg::LIM_WARN
      |=> tx_bus_state_q == crf_pkg::CRF_OK)
      else $error("transmitter status not ok");

   a_write_one_clears: assert property ( // [RL10]
      @(posedge i_clk_sys) disable iff (i_reset)
      clr_wake && !wake_evt |=> !wake_flag_q)
      else $error("write one did not clear");

   a_write_zero_keeps: assert property ( // [RL10]
      @(posedge i_clk_sys) disable iff (i_reset)
      wake_flag_q && !clr_wake && !init_hold |=> wake_flag_q)
      else $error("flag lost without clear");

   a_tx_busoff_code: assert property ( // [RL11]
      @(posedge i_clk_sys) disable iff (i_reset)
      !status_change_flag_q && i_err_cnt.tec >= crf_pkg::LIM_OFF
      |=> tx_bus_state_q == crf_pkg::CRF_OFF)
      else $error("bus-off code wrong");

   a_rx_warn_code: assert property ( // [RL11]
      @(posedge i_clk_sys) disable iff (i_reset)
      !status_change_flag_q && rec_wide >= crf_pkg::LIM_WARN && rec_wide < crf_pkg::LIM_PASSIVE
      |=> rx_bus_state_q == crf_pkg::CRF_WARN)
      else $error("receiver warning code wrong");

   a_rx_passive_code: assert property ( // [RL11]
      @(posedge i_clk_sys) disable iff (i_reset)
      !status_change_flag_q && rec_wide >= crf_pkg::LIM_PASSIVE
      |=> rx_bus_state_q == crf_pkg::CRF_PASSIVE)
      else $error("receiver passive code wrong");

   a_tx_warn_code: assert property ( // [RL11]
      @(posedge i_clk_sys) disable iff (i_reset)
      !status_change_flag_q && i_err_cnt.tec >= crf_pkg::LIM_WARN
         && i_err_cnt.tec < crf_pkg::LIM_PASSIVE |=> tx_bus_state_q == crf_pkg::CRF_WARN)
      else $error("transmitter warning code wrong");

   a_tx_passive_code: assert property ( // [RL11]
      @(posedge i_clk_sys) disable iff (i_reset)
      !status_change_flag_q && i_err_cnt.tec >= crf_pkg::LIM_PASSIVE
         && i_err_cnt.tec < crf_pkg::LIM_OFF |=> tx_bus_state_q == crf_pkg::CRF_PASSIVE)
      else $error("transmitter passive code wrong");

   a_rx_never_off: assert property ( // [RL11]
      @(posedge i_clk_sys) disable iff (i_reset)
      rx_bus_state_q != crf_pkg::CRF_OFF)
      else $error("receiver shows bus-off");

   a_fields_enter_init: assert property ( // [RL2]
      @(posedge i_clk_sys) disable iff (i_reset)
      init_hold && status_change_flag_q |=> $stable(rx_bus_state_q) && $stable(tx_bus_state_q))
      else $error("status fields reset by init");

   a_fields_follow: assert property ( // [RL7]
      @(posedge i_clk_sys) disable iff (i_reset)
      !status_change_flag_q
      |=> rx_bus_state_q == $past(rx_cur) && tx_bus_state_q == $past(tx_cur))
      else $error("status fields not tracking");

   a_wake_irq_masked: assert property ( // [RL4]
      @(posedge i_clk_sys) disable iff (i_reset)
      !wake_ie_q |-> !o_wake_irq)
      else $error("masked wake interrupt raised");

   a_status_irq_masked: assert property ( // [RL6]
      @(posedge i_clk_sys) disable iff (i_reset)
      !status_ie_q |-> !o_status_irq)
      else $error("masked error interrupt raised");

   a_status_clears: assert property ( // [RL10]
      @(posedge i_clk_sys) disable iff (i_reset)
      clr_stat && !stat_evt |=> !status_change_flag_q)
      else $error("status change flag not cleared");

   a_set_beats_clear: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_reset)
      clr_wake && wake_evt |=> wake_flag_q)
      else $error("clear beat a wake event");

   a_init_blocks_write: assert property ( // [RL1]
      @(posedge i_clk_sys) disable iff (i_reset)
      i_bus.wr && i_bus.addr == crf_pkg::OFS_FLAGS && !init_free && !init_hold && wake_flag_q
      |=> wake_flag_q)
      else $error("flag write taken in init");

   a_status_quiet: assert property ( // [RL5]
      @(posedge i_clk_sys) disable iff (i_reset)
      !status_change_flag_q && !stat_evt |=> !status_change_flag_q)
      else $error("status change flag set without change");

   a_wake_quiet: assert property ( // [RL3]
      @(posedge i_clk_sys) disable iff (i_reset)
      !wake_flag_q && !(act_s2_q && i_sleep_mode && i_wake_enable) |=> !wake_flag_q)
      else $error("wake flag set without activity");

   a_rdata_idle: assert property ( // [RL10]
      @(posedge i_clk_sys) disable iff (i_reset)
      !i_bus.rd |=> o_rdata == crf_pkg::RST_DATA)
      else $error("read data outside read cycle");

   a_rdata_fields: assert property ( // [RL10]
      @(posedge i_clk_sys) disable iff (i_reset)
      i_bus.rd && i_bus.addr == crf_pkg::OFS_FLAGS
      |=> o_rdata[crf_pkg::RX_HI:crf_pkg::RX_LO] == $past(rx_bus_state_q)
         && o_rdata[crf_pkg::TX_HI:crf_pkg::TX_LO] == $past(tx_bus_state_q))
      else $error("status fields misread");
endmodule
`default_nettype wire

//--- tb/crf_can_node.sv
// Far side model: bus activity through the transceiver and error counters
`default_nettype none
module crf_can_node (
   // Clock
   input wire logic i_clk_sys,
   // Towards the block
   output logic o_bus_activity,
   output var crf_pkg::crf_err_cnt_t o_err_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_bus_activity = 1'b0;
      o_err_cnt = '0;
   end
   // Dominant edges arrive off the clock grid
   task automatic send_activity();
      @(posedge i_clk_sys);
      #1.3 o_bus_activity = 1'b1;
      #11 o_bus_activity = 1'b0;
   endtask
   task automatic set_counts(input logic [8:0] t, input logic [7:0] r);
      @(posedge i_clk_sys);
      o_err_cnt <= '{tec: t, rec: r};
   endtask
endmodule
`default_nettype wire

//--- tb/crf_receive_flags_test.sv
// Self-checking bench for the receive flag register
`default_nettype none
module crf_receive_flags_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] FLG = crf_pkg::OFS_FLAGS;
   localparam logic [3:0] ENR = crf_pkg::OFS_IRQ_EN;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   crf_pkg::crf_bus_req_t i_bus = '0;
   logic init_rq = 1'b0;
   logic init_ak = 1'b0;
   logic sleep = 1'b0;
   logic wen = 1'b0;
   logic rd_seen = 1'b0;
   logic [7:0] o_rdata;
   logic o_wake_irq, o_status_irq, o_irq, act, chg;
   crf_pkg::crf_err_cnt_t cnt;
   logic [7:0] exp_q[$];
   logic [31:0] rnd = 32'hB2B706E0;
   logic [3:0] prev, cur;
   logic [8:0] t;
   logic [7:0] r;
   int fails = 0;
   int total_checks = 0;
   always #2 i_clk_sys = ~i_clk_sys;
   crf_can_node crf_can_node_i (.i_clk_sys(i_clk_sys), .o_bus_activity(act), .o_err_cnt(cnt));
   crf_receive_flags crf_receive_flags_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .i_bus(i_bus), .o_rdata(o_rdata), .i_init_request(init_rq), .i_init_acknowledge(init_ak),
      .i_sleep_mode(sleep), .i_wake_enable(wen), .i_err_cnt(cnt), .i_bus_activity(act),
      .o_wake_irq(o_wake_irq), .o_status_irq(o_status_irq), .o_irq(o_irq));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Receiver code in 3:2, transmitter code in 1:0
   function automatic logic [3:0] code(input logic [8:0] tc, input logic [7:0] rc);
      code[3:2] = rc < 8'h60 ? 2'h0 : rc < 8'h80 ? 2'h1 : 2'h2;
      code[1:0] = tc < 9'h060 ? 2'h0 : tc < 9'h080 ? 2'h1 : tc < 9'h100 ? 2'h2 : 2'h3;
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk_sys);
      i_bus <= '0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge i_clk_sys);
      i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk_sys);
      i_bus <= '0;
      @(posedge i_clk_sys);
   endtask
   // Order: wake, status, combined
   task automatic irq(input logic [2:0] e);
      #1;
      check({5'h00, o_wake_irq, o_status_irq, o_irq}, {5'h00, e});
   endtask
   task automatic close_out();
      if (exp_q.size() != 0) begin
         fails++;
         $display("CHECK FAILED at %0t: %0d reads never answered", $time, exp_q.size());
      end
      $display("checks %0d failures %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Read data stands only in the cycle after the strobe
   always @(posedge i_clk_sys) begin
      if (rd_seen) check(o_rdata, exp_q.pop_front());
      rd_seen <= i_bus.rd;
   end
   initial begin
      #(40000 * 4);
      fails++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      prev = 4'h0;
      rd(FLG, 8'h00);
      rd(4'hF, 8'h00);
      wr(ENR, 8'hFF);
      rd(ENR, 8'hC0);
      sleep <= 1'b1;
      wen <= 1'b1;
      crf_can_node_i.send_activity();
      repeat (4) @(posedge i_clk_sys);
      rd(FLG, 8'h80);
      irq(3'b101);
      wr(FLG, 8'h3F);
      rd(FLG, 8'h80);
      wr(ENR, 8'h40);
      irq(3'b000);
      wr(FLG, 8'h80);
      rd(FLG, 8'h00);
      wen <= 1'b0;
      crf_can_node_i.send_activity();
      repeat (4) @(posedge i_clk_sys);
      rd(FLG, 8'h00);
      wr(ENR, 8'hC0);
      for (int i = 0; i < 12; i++) begin
         rnd = xs(rnd);
         t = rnd[8:0];
         r = rnd[23:16];
         crf_can_node_i.set_counts(t, r);
         cur = code(t, r);
         chg = cur != prev;
         rd(FLG, {1'b0, chg, cur, 2'b00});
         if (chg) irq(3'b011);
         crf_can_node_i.set_counts(t ^ 9'h100, r ^ 8'h80);
         prev = code(t ^ 9'h100, r ^ 8'h80);
         rd(FLG, {2'b01, chg ? cur : prev, 2'b00});
         wr(FLG, 8'h40);
      end
      wr(ENR, 8'h00);
      cur = (prev == 4'h0) ? 4'h3 : 4'h0;
      crf_can_node_i.set_counts({cur[0], 8'h00}, 8'h00);
      rd(FLG, {2'b01, cur, 2'b00});
      irq(3'b000);
      wr(ENR, 8'hC0);
      irq(3'b011);
      @(posedge i_clk_sys);
      init_rq <= 1'b1;
      init_ak <= 1'b1;
      wen <= 1'b1;
      crf_can_node_i.send_activity();
      repeat (4) @(posedge i_clk_sys);
      rd(FLG, {2'b00, cur, 2'b00});
      init_rq <= 1'b0;
      init_ak <= 1'b0;
      crf_can_node_i.send_activity();
      repeat (4) @(posedge i_clk_sys);
      rd(FLG, {2'b10, cur, 2'b00});
      wr(FLG, 8'h80);
      rd(FLG, {2'b00, cur, 2'b00});
      crf_can_node_i.send_activity();
      repeat (4) @(posedge i_clk_sys);
      init_rq <= 1'b1;
      wr(FLG, 8'h80);
      rd(FLG, {2'b10, cur, 2'b00});
      init_rq <= 1'b0;
      wr(FLG, 8'h80);
      rd(FLG, {2'b00, cur, 2'b00});
      repeat (2) @(posedge i_clk_sys);
      close_out();
   end
endmodule
`default_nettype wire
